/* testbench/call_exec_checker.sv */
module call_exec_checker #(
  parameter bit TRACK_SFA = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire call_pkg::stack_wr_t stack_wr,
  input wire call_pkg::pc_ld_t pc_load,
  input wire logic sp_we,
  input wire logic [15:0] sp_wdata,
  input wire logic sfa_clr,
  input wire logic ir_nop,
  input wire logic busy,
  input wire logic illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_lo;
    stack_wr.we && !sp_we;
  endsequence
  sequence s_hi;
    stack_wr.we && sp_we;
  endsequence
  AST_PUSH_ORDER: assert property (s_lo |=> s_hi)
    else $error("high push does not follow low push");
  AST_HI_ADDR: assert property (s_lo ##1 s_hi |->
    stack_wr.addr == $past(stack_wr.addr) + 16'h0002) else $error("high push address");
  AST_SP_STEP: assert property (s_hi |-> sp_wdata == stack_wr.addr + 16'h0002)
    else $error("stack pointer not advanced by two pushes");
  AST_HI_BYTE: assert property (s_hi |-> stack_wr.data[15:8] == 8'h00)
    else $error("upper return word not a byte");
  AST_LOAD_GAP: assert property ((TRACK_SFA && stack_wr.we && sp_we) |->
    !pc_load.ld ##1 !pc_load.ld ##1 pc_load.ld) else $error("load not four cycles");
  AST_NOP: assert property (pc_load.ld |-> ir_nop && !busy)
    else $error("load without nop or busy still high");
  AST_SFA_CLR: assert property (pc_load.ld |-> sfa_clr == TRACK_SFA)
    else $error("flag clear missing at load");
  AST_PC0: assert property (pc_load.ld |-> !pc_load.value[0])
    else $error("target bit 0 set");
  AST_FETCH_FIRST: assert property (fetch_req |=> !stack_wr.we && !pc_load.ld)
    else $error("push before second word");
  AST_REFUSE: assert property (illegal |-> !stack_wr.we ##1 !stack_wr.we && !pc_load.ld)
    else $error("refused call still stacked");
endmodule : call_exec_checker

/* testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic ill;
    logic [15:0] lo_a;
    logic [15:0] lo_d;
    logic [15:0] hi_d;
    logic [23:0] tgt;
  } note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ins_valid, fetch_req, fetch_valid, sp_we, sfa_in, sfa_clr, ir_nop, busy, illegal, stack_frame_active_flag;
  logic [23:0] ins_word, ins_pc, fetch_word, pc, lit;
  logic [3:0] reg_rd_addr;
  logic [15:0] reg_rd_data, sp_in, sp_wdata, lo_a, lo_d, hi_d;
  call_pkg::stack_wr_t stack_wr;
  call_pkg::pc_ld_t pc_load;
  logic [15:0] rf [16];
  logic [31:0] seed = 32'h1;
  note_t exp_q[$];
  note_t n;
  int err_count = 0;
  int compares = 0;

  always #2.5 sys_clk = ~sys_clk;
  assign reg_rd_data = rf[reg_rd_addr];

  call_exec call_exec_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ins_valid(ins_valid),
    .ins_word(ins_word), .ins_pc(ins_pc), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .sp_in(sp_in), .sp_we(sp_we), .sp_wdata(sp_wdata), .stack_wr(stack_wr),
    .pc_load(pc_load), .sfa_in(sfa_in), .sfa_clr(sfa_clr), .ir_nop(ir_nop), .busy(busy),
    .illegal(illegal));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic note_t mk(logic ill, logic [23:0] ret, logic [23:0] tgt);
    return note_t'{ill, sp_in, {ret[15:1], stack_frame_active_flag}, {8'h00, ret[23:16]}, tgt};
  endfunction : mk

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // one call at a time; the stack pointer the note expects is the one current now
  task automatic call(input logic [23:0] w, input logic [23:0] w2, input note_t e, input bit out);
    int k;
    @(negedge sys_clk);
    ins_valid = 1'b1;
    ins_word = w;
    ins_pc = pc;
    sfa_in = stack_frame_active_flag;
    if (out) exp_q.push_back(e);
    @(negedge sys_clk);
    ins_valid = 1'b0;
    if (w[23:16] == 8'h02) begin
      k = 0;
      while (!fetch_req && k < 20) begin
        @(negedge sys_clk);
        k++;
      end
      chk("fetch request wait", 24'(k >= 20), 24'h0);
      @(negedge sys_clk);
      fetch_valid = 1'b1;
      fetch_word = w2;
      @(negedge sys_clk);
      fetch_valid = 1'b0;
    end
    k = 0;
    while (busy && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    chk("busy wait", 24'(k >= 20), 24'h0);
  endtask : call

  always @(negedge sys_clk) begin
    if (stack_wr.we && !sp_we) begin
      lo_a = stack_wr.addr;
      lo_d = stack_wr.data;
    end
    if (sp_we) begin
      hi_d = stack_wr.data;
      sp_in <= sp_wdata;
    end
    if (illegal || pc_load.ld) begin
      if (exp_q.size() == 0) chk("unexpected result", 24'h1, 24'h0);
      else begin
        n = exp_q.pop_front();
        chk("refused", 24'(illegal), 24'(n.ill));
        if (pc_load.ld) begin
          chk("low push address", 24'(lo_a), 24'(n.lo_a));
          chk("low push data", 24'(lo_d), 24'(n.lo_d));
          chk("high push data", 24'(hi_d), 24'(n.hi_d));
          chk("stack pointer", 24'(sp_in), 24'(n.lo_a + 16'h0004));
          chk("target", pc_load.value, n.tgt);
          chk("nop", 24'(ir_nop), 24'h1);
          chk("flag clear", 24'(sfa_clr), 24'h1);
        end
      end
    end
  end

  initial begin
    ins_valid = 1'b0;
    ins_word = '0;
    ins_pc = '0;
    fetch_valid = 1'b0;
    fetch_word = '0;
    sp_in = 16'ha268;
    sfa_in = 1'b0;
    stack_frame_active_flag = 1'b0;
    pc = '0;
    foreach (rf[i]) rf[i] = 16'(rnd());
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      // first pass: top literal and a return address that carries into the upper byte
      pc = (i == 0) ? 24'h7ffffc : 24'(rnd()) & 24'h7ffffe;
      lit = (i == 0) ? 24'h7ffffe : 24'(rnd()) & 24'h7ffffe;
      stack_frame_active_flag = pc[1];
      call({8'h02, lit[15:0]}, {17'h0, lit[22:16]}, mk(1'b0, pc + 24'h4, lit), 1'b1);
    end
    $display("direct calls done");
    for (int s = 0; s < 16; s++) begin
      pc = 24'(rnd()) & 24'hfffffe;
      stack_frame_active_flag = pc[1];
      call({12'h010, 8'h00, 4'(s)}, 24'h0,
        mk(1'b0, pc + 24'h2, {8'h00, rf[s][15:1], 1'b0}), 1'b1);
    end
    $display("short indirect calls done");
    for (int s = 0; s < 14; s += 2) begin
      pc = 24'(rnd()) & 24'hfffffe;
      stack_frame_active_flag = pc[1];
      call({8'h01, 1'b1, 4'(s + 1), 7'h00, 4'(s)}, 24'h0,
        mk(1'b0, pc + 24'h2, {pc[23], rf[s + 1][6:0], rf[s][15:1], 1'b0}), 1'b1);
    end
    $display("long indirect calls done");
    call({8'h01, 1'b1, 4'h4, 7'h00, 4'h3}, 24'h0, mk(1'b1, 24'h0, 24'h0), 1'b1);
    call({8'h01, 1'b1, 4'hf, 7'h00, 4'he}, 24'h0, mk(1'b1, 24'h0, 24'h0), 1'b1);
    call({8'h02, 16'h1234}, 24'h000080, mk(1'b1, 24'h0, 24'h0), 1'b1);
    call(24'hefffff, 24'h0, mk(1'b1, 24'h0, 24'h0), 1'b0);
    repeat (8) @(negedge sys_clk);
    chk("pending results", 24'(exp_q.size()), 24'h0);
    $display("refused calls done");
    finish_test();
  end

  initial begin
    #20000;
    err_count++;
    finish_test();
  end
endmodule : tb_top

bind call_exec call_exec_checker #(.TRACK_SFA(TRACK_SFA)) call_exec_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .fetch_req(fetch_req), .stack_wr(stack_wr),
  .pc_load(pc_load), .sp_we(sp_we), .sp_wdata(sp_wdata), .sfa_clr(sfa_clr),
  .ir_nop(ir_nop), .busy(busy), .illegal(illegal));

/* verilog/call_decode.sv */
module call_decode #(
  parameter bit TRACK_SFA = 1'b1
) (
  input wire logic [23:0] ins_word,
  output call_pkg::call_dec_t dec
);

  logic [7:0] opc;
  logic long_form;
  logic zeros_ok;

  assign opc = ins_word[call_pkg::OPC_MSB:call_pkg::OPC_LSB];
  assign long_form = ins_word[call_pkg::LONG_BIT];
  // the bits between the two register fields must be zero for any indirect form
  assign zeros_ok = (ins_word[call_pkg::ZERO_MSB:call_pkg::SRC_MSB + 1] == 7'h00);

  always_comb begin
    dec = '0;
    dec.src = ins_word[call_pkg::SRC_MSB:call_pkg::SRC_LSB];
    dec.upr = ins_word[call_pkg::UPR_MSB:call_pkg::UPR_LSB];
    dec.lit_lo = ins_word[call_pkg::LIT_LO_MSB:call_pkg::LIT_LO_LSB];
    if (opc == call_pkg::OPC_DIRECT && !ins_word[0]) begin
      dec.is_call = 1'b1;
      dec.direct = 1'b1;
    end else if (opc == call_pkg::OPC_INDIRECT && zeros_ok) begin
      if (!long_form && dec.upr == 4'h0) begin
        dec.is_call = 1'b1;
        dec.short_ind = 1'b1;
      end else if (long_form && TRACK_SFA) begin
        dec.is_call = 1'b1;
        dec.long_ind = 1'b1;
        // only even low registers up to twelve pair with a following register
        dec.bad_reg = dec.src[0] || (dec.src > call_pkg::LONG_SRC_MAX);
      end
    end
  end

endmodule : call_decode

/* verilog/call_exec.sv */
module call_exec #(
  parameter bit TRACK_SFA = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ins_valid,
  input wire logic [23:0] ins_word,
  input wire logic [23:0] ins_pc,
  output logic fetch_req,
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  output logic [3:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic [15:0] sp_in,
  output logic sp_we,
  output logic [15:0] sp_wdata,
  output call_pkg::stack_wr_t stack_wr,
  output call_pkg::pc_ld_t pc_load,
  input wire logic sfa_in,
  output logic sfa_clr,
  output logic ir_nop,
  output logic busy,
  output logic illegal
);

  typedef struct packed {
    call_pkg::call_state_t state;
    logic direct;
    logic long_ind;
    logic pc_msb;
    logic [3:0] upr;
    logic [23:0] ret;
    logic [22:0] target;
    logic [15:0] sp;
    logic fetch_req;
    logic [3:0] rd_addr;
    logic sp_we;
    logic [15:0] sp_wdata;
    call_pkg::stack_wr_t stk;
    call_pkg::pc_ld_t pcl;
    logic sfa_clr;
    logic ir_nop;
    logic busy;
    logic illegal;
  } exec_state_t;

  localparam exec_state_t EXEC_RST = '{
    state: call_pkg::ST_IDLE,
    direct: 1'b0,
    long_ind: 1'b0,
    pc_msb: 1'b0,
    upr: call_pkg::SEL_RST,
    ret: call_pkg::PC_RST,
    target: call_pkg::PC_RST[22:0],
    sp: call_pkg::WORD_RST,
    fetch_req: 1'b0,
    rd_addr: call_pkg::SEL_RST,
    sp_we: 1'b0,
    sp_wdata: call_pkg::WORD_RST,
    stk: '0,
    pcl: '0,
    sfa_clr: 1'b0,
    ir_nop: 1'b0,
    busy: 1'b0,
    illegal: 1'b0
  };

  exec_state_t st_ff;
  exec_state_t nxt_st;
  call_pkg::call_dec_t dec;

  call_decode #(
    .TRACK_SFA(TRACK_SFA)
  ) u_decode (
    .ins_word(ins_word),
    .dec(dec)
  );

  // return address: past both words of a direct call, past the single word otherwise
  function automatic logic [23:0] ret_addr(
    input logic [23:0] pc,
    input logic direct
  );
    logic [23:0] inc;
    inc = direct ? call_pkg::RET_INC_DIRECT : call_pkg::RET_INC_ONE_WORD;
    return pc + inc;
  endfunction : ret_addr

  // low stack word; bit 0 carries the frame flag only where it is tracked
  function automatic logic [15:0] low_word(
    input logic [23:0] ret,
    input logic stack_frame_active_flag
  );
    logic [15:0] w;
    w = ret[15:0];
    if (TRACK_SFA) begin
      w[0] = stack_frame_active_flag;
    end
    return w;
  endfunction : low_word

  always_comb begin
    nxt_st = st_ff;
    // single-cycle strobes fall back every cycle unless re-raised below
    nxt_st.fetch_req = 1'b0;
    nxt_st.sp_we = 1'b0;
    nxt_st.stk.we = 1'b0;
    nxt_st.pcl.ld = 1'b0;
    nxt_st.sfa_clr = 1'b0;
    nxt_st.ir_nop = 1'b0;
    nxt_st.illegal = 1'b0;

    case (st_ff.state)
      call_pkg::ST_IDLE: begin
        if (ins_valid && dec.is_call) begin
          nxt_st.direct = dec.direct;
          nxt_st.long_ind = dec.long_ind;
          nxt_st.pc_msb = ins_pc[call_pkg::PC_W - 1];
          nxt_st.upr = dec.upr;
          nxt_st.ret = ret_addr(ins_pc, dec.direct);
          nxt_st.target = '0;
          if (dec.bad_reg) begin
            // odd or out-of-range low register: refused, nothing is stacked
            nxt_st.illegal = 1'b1;
          end else if (dec.direct) begin
            nxt_st.target[15:1] = dec.lit_lo;
            nxt_st.fetch_req = 1'b1;
            nxt_st.busy = 1'b1;
            nxt_st.state = call_pkg::ST_FETCH;
          end else begin
            nxt_st.rd_addr = dec.src;
            nxt_st.sp = sp_in;
            nxt_st.stk.we = 1'b1;
            nxt_st.stk.addr = sp_in;
            nxt_st.stk.data = low_word(ret_addr(ins_pc, 1'b0), sfa_in);
            nxt_st.busy = 1'b1;
            nxt_st.state = call_pkg::ST_PUSH_HI;
          end
        end
      end

      call_pkg::ST_FETCH: begin
        // the second word is consumed here as operand data, never issued
        if (fetch_valid) begin
          if (fetch_word[call_pkg::PC_W - 1:call_pkg::LIT_HI_W] != 17'h00000) begin
            // malformed operand word: abandon before anything reaches the stack
            nxt_st.illegal = 1'b1;
            nxt_st.busy = 1'b0;
            nxt_st.state = call_pkg::ST_IDLE;
          end else begin
            nxt_st.target[22:16] = fetch_word[call_pkg::LIT_HI_MSB:0];
            nxt_st.sp = sp_in;
            nxt_st.stk.we = 1'b1;
            nxt_st.stk.addr = sp_in;
            nxt_st.stk.data = low_word(st_ff.ret, sfa_in);
            nxt_st.state = call_pkg::ST_PUSH_HI;
          end
        end
      end

      call_pkg::ST_PUSH_HI: begin
        // upper return byte goes one slot above the low word
        nxt_st.stk.we = 1'b1;
        nxt_st.stk.addr = st_ff.sp + call_pkg::SP_STEP;
        nxt_st.stk.data = {8'h00, st_ff.ret[23:16]};
        nxt_st.sp_we = 1'b1;
        nxt_st.sp_wdata = st_ff.sp + call_pkg::SP_STEP + call_pkg::SP_STEP;
        if (!st_ff.direct) begin
          // register data answers the address registered last cycle
          nxt_st.target[15:0] = {reg_rd_data[15:1], 1'b0};
          if (!st_ff.long_ind) begin
            nxt_st.target[22:16] = '0;
          end
        end
        if (st_ff.long_ind) begin
          nxt_st.rd_addr = st_ff.upr;
        end
        if (TRACK_SFA) begin
          nxt_st.state = call_pkg::ST_TGT;
        end else begin
          // plain variant finishes in two cycles: load issued right here
          nxt_st.pcl.ld = 1'b1;
          nxt_st.pcl.value = {1'b0, nxt_st.target};
          nxt_st.ir_nop = 1'b1;
          nxt_st.busy = 1'b0;
          nxt_st.state = call_pkg::ST_IDLE;
        end
      end

      call_pkg::ST_TGT: begin
        if (st_ff.long_ind) begin
          // upper bits 15..7 of the upper register never reach the pc
          nxt_st.target[22:16] = reg_rd_data[call_pkg::LIT_HI_MSB:0];
        end
        nxt_st.state = call_pkg::ST_LOAD;
      end

      call_pkg::ST_LOAD: begin
        nxt_st.pcl.ld = 1'b1;
        if (st_ff.long_ind) begin
          nxt_st.pcl.value = {st_ff.pc_msb, st_ff.target};
        end else begin
          nxt_st.pcl.value = {1'b0, st_ff.target};
        end
        nxt_st.ir_nop = 1'b1;
        // flag is cleared only after both words are on the stack
        nxt_st.sfa_clr = 1'b1;
        nxt_st.busy = 1'b0;
        nxt_st.state = call_pkg::ST_IDLE;
      end

      default: begin
        nxt_st = EXEC_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_ff <= EXEC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fetch_req = st_ff.fetch_req;
  assign reg_rd_addr = st_ff.rd_addr;
  assign sp_we = st_ff.sp_we;
  assign sp_wdata = st_ff.sp_wdata;
  assign stack_wr = st_ff.stk;
  assign pc_load = st_ff.pcl;
  assign sfa_clr = st_ff.sfa_clr;
  assign ir_nop = st_ff.ir_nop;
  assign busy = st_ff.busy;
  assign illegal = st_ff.illegal;

endmodule : call_exec

/* verilog/call_pkg.sv */
package call_pkg;

  localparam int unsigned PC_W = 24;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned REG_SEL_W = 4;

  localparam logic [7:0] OPC_DIRECT = 8'h02;
  localparam logic [7:0] OPC_INDIRECT = 8'h01;
  localparam int unsigned OPC_MSB = 23;
  localparam int unsigned OPC_LSB = 16;
  localparam int unsigned LONG_BIT = 15;
  localparam int unsigned UPR_MSB = 14;
  localparam int unsigned UPR_LSB = 11;
  localparam int unsigned ZERO_MSB = 10;
  localparam int unsigned SRC_MSB = 3;
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned LIT_LO_MSB = 15;
  localparam int unsigned LIT_LO_LSB = 1;
  localparam int unsigned LIT_HI_MSB = 6;
  localparam int unsigned LIT_HI_W = 7;

  localparam logic [23:0] RET_INC_DIRECT = 24'h000004;
  localparam logic [23:0] RET_INC_ONE_WORD = 24'h000002;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [3:0] LONG_SRC_MAX = 4'hc;

  localparam int unsigned CYC_TRACK = 4;
  localparam int unsigned CYC_PLAIN = 2;

  localparam logic [23:0] PC_RST = 24'h000000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] SEL_RST = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_FETCH   = 5'b00010,
    ST_PUSH_HI = 5'b00100,
    ST_TGT     = 5'b01000,
    ST_LOAD    = 5'b10000
  } call_state_t;

  typedef struct packed {
    logic is_call;
    logic direct;
    logic short_ind;
    logic long_ind;
    logic bad_reg;
    logic [3:0] src;
    logic [3:0] upr;
    logic [14:0] lit_lo;
  } call_dec_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } stack_wr_t;

  typedef struct packed {
    logic ld;
    logic [23:0] value;
  } pc_ld_t;

endpackage : call_pkg
